// >>> hdl/warning_and_rtd_supervisor.sv
`timescale 1ns/1ps

// Summary of operation
// [R1] warnings keep protection running; ready indicator stays steadily lit
// [R2] concurrent warnings give one code summing active weights
// [R3] warning code ignores clears and follows the live fault condition
// [R4] weights 1,2,4,8,16,32 for battery, tcs, psu temp, comm, module, range
// [R5] open or short on sensors one to six sets weights 64 to 2048
// [R6] open or short on thermistors one and two sets 4096 and 8192
// [R7] trip supervision warning reaches second signal output only when enabled
// [R8] reference check after every sample; deviation over 1.5 percent discards it
// [R9] reference fault lasting eight seconds takes all inputs out
// [R10] inputs come back once reference fault is gone
// [R11] failed self calibration takes all inputs out; success restores them
// [R12] single input out when outside -4..104 percent or open or shorted
// [R13] fault contact energized normally, dropped on self supervision fault
// [R14] three trip route groups feed power outputs; two groups feed signal outputs
// [R15] default trips from non-thermal stages to outputs one and two; inhibit to three
// [R16] default start and alarm of non-thermal stages to signal outputs one and two
// [R17] each digital input has its own function group; recorder trigger separate
// [R18] warning code is a 14-bit one-hot-per-type vector combined by or
// [R19] filter timer restarts on every sample passing reference check
module warning_and_rtd_supervisor #(
    parameter longint FILTER_CYCLES = wrs_pkg::FILTER_CYCLES
) (
    input  wire logic                        clk_sys,
    input  wire logic                        rstn,
    input  wire logic [7:0]                  reg_addr,
    input  wire logic [31:0]                 reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [31:0]                 reg_rdata,
    output logic                             irq,
    input  wire logic                        battery_low,
    input  wire logic                        trip_circuit_fault,
    input  wire logic                        psu_over_temp,
    input  wire logic                        comm_module_fault,
    input  wire logic                        rtd_module_fault,
    input  wire logic                        sensor_range_error,
    input  wire logic [1:0]                  thermistor_open_short,
    input  wire logic                        self_test_fault,
    input  wire logic                        sample_valid,
    input  wire logic [2:0]                  sample_channel,
    input  wire logic signed [15:0]          sample_value,
    input  wire logic                        sample_open_short,
    input  wire logic [15:0]                 ref_measured,
    input  wire logic [15:0]                 ref_setpoint,
    input  wire logic                        calib_done,
    input  wire logic                        calib_pass,
    input  wire logic [wrs_pkg::STAGES-1:0]  stage_trip,
    input  wire logic [wrs_pkg::STAGES-1:0]  stage_start_alarm,
    input  wire logic                        restart_inhibit,
    input  wire logic [wrs_pkg::DI_N-1:0]    digital_in,
    output logic                             ready_led,
    output logic                             internal_fault_contact,
    output logic                             power_output_one,
    output logic                             power_output_two,
    output logic                             power_output_three,
    output logic                             signal_output_one,
    output logic                             signal_output_two,
    output logic [wrs_pkg::RTD_CH-1:0]       rtd_in_service,
    output logic                             sample_accept,
    output logic [wrs_pkg::DI_N-1:0]         di_blocking,
    output logic [wrs_pkg::DI_N-1:0]         di_unlatch,
    output logic [wrs_pkg::DI_N-1:0]         di_remote_setting,
    output logic                             recorder_trigger
);

    // ----------------
    // configuration registers
    // ----------------
    logic [31:0]                   ctrl;
    logic [31:0]                   trip_routing_switchgroups;
    logic [31:0]                   signal_routing_groups;
    logic [31:0]                   input_function_switchgroups;
    logic [wrs_pkg::IRQ_W-1:0]     irq_status;
    logic [wrs_pkg::IRQ_W-1:0]     irq_mask;
    logic                          trip_supervision_route_bit;
    logic                          recorder_trigger_select;

    assign trip_supervision_route_bit = ctrl[wrs_pkg::CTRL_TRIP_SUP];
    assign recorder_trigger_select    = ctrl[wrs_pkg::CTRL_REC_TRIG];

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ctrl                        <= wrs_pkg::CTRL_RST;
            trip_routing_switchgroups   <= wrs_pkg::TRIP_ROUTE_RST;  // R15
            signal_routing_groups       <= wrs_pkg::SIG_ROUTE_RST;   // R16
            input_function_switchgroups <= wrs_pkg::INPUT_FUNC_RST;
            irq_mask                    <= '0;
        end else if (reg_wr) begin
            unique case (reg_addr)
                wrs_pkg::ADDR_CTRL:       ctrl <= reg_wdata;
                wrs_pkg::ADDR_TRIP_ROUTE: trip_routing_switchgroups <= reg_wdata;
                wrs_pkg::ADDR_SIG_ROUTE:  signal_routing_groups <= reg_wdata;
                wrs_pkg::ADDR_INPUT_FUNC: input_function_switchgroups <= reg_wdata;
                wrs_pkg::ADDR_IRQ_MASK:   irq_mask <= reg_wdata[wrs_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // ----------------
    // rtd reference check and filter timer
    // ----------------
    logic [15:0] ref_dev;
    logic        ref_bad;
    logic [31:0] filter_cnt;
    logic        ref_fault_all;
    logic        calib_fault_all;
    logic        all_inputs_off;

    assign ref_dev = (ref_measured > ref_setpoint) ? ref_measured - ref_setpoint
                                                   : ref_setpoint - ref_measured;
    assign ref_bad = sample_valid && ref_dev > wrs_pkg::REF_TOL;      // R8
    assign sample_accept = sample_valid && !ref_bad && !all_inputs_off; // R8

    // runs on from the first discard and holds at expiry; only a passing sample clears it
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            filter_cnt    <= '0;
            ref_fault_all <= 1'b0;
        end else if (sample_valid && !ref_bad) begin
            filter_cnt    <= '0;                        // R19
            ref_fault_all <= 1'b0;                      // R10
        end else if (filter_cnt == 32'(FILTER_CYCLES - 1)) begin
            ref_fault_all <= 1'b1;                      // R9
        end else if (ref_bad || filter_cnt != '0) begin
            filter_cnt <= filter_cnt + 32'd1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn)
            calib_fault_all <= 1'b0;
        else if (calib_done)
            calib_fault_all <= !calib_pass;                           // R11
    end

    assign all_inputs_off = ref_fault_all || calib_fault_all;

    // ----------------
    // per-channel out-of-service
    // ----------------
    logic [wrs_pkg::RTD_CH-1:0] ch_bad;
    logic [wrs_pkg::RTD_CH-1:0] ch_open;

    genvar g;
    generate
        for (g = 0; g < wrs_pkg::RTD_CH; g++) begin : g_ch
            always_ff @(posedge clk_sys) begin
                if (!rstn) begin
                    ch_bad[g]  <= 1'b0;
                    ch_open[g] <= 1'b0;
                end else if (sample_accept && sample_channel == 3'(g)) begin
                    ch_bad[g]  <= sample_value < wrs_pkg::RANGE_LOW ||
                                  sample_value > wrs_pkg::RANGE_HIGH;  // R12
                    ch_open[g] <= sample_open_short;                   // R12
                end
            end
            assign rtd_in_service[g] = !all_inputs_off && !ch_bad[g] && !ch_open[g];
        end
    endgenerate

    // ----------------
    // warning code
    // ----------------
    logic [wrs_pkg::WARN_W-1:0] warn_code;
    logic [wrs_pkg::WARN_W-1:0] next_warn_code;

    // bit per weight, so the or of bits equals the sum of weights
    always_comb begin
        next_warn_code = '0;
        next_warn_code[wrs_pkg::BIT_BATT]     = battery_low;            // R4
        next_warn_code[wrs_pkg::BIT_TCS]      = trip_circuit_fault;
        next_warn_code[wrs_pkg::BIT_PSU_TEMP] = psu_over_temp;
        next_warn_code[wrs_pkg::BIT_COMM]     = comm_module_fault;
        next_warn_code[wrs_pkg::BIT_RTD_MOD]  = rtd_module_fault || all_inputs_off;
        next_warn_code[wrs_pkg::BIT_RANGE]    = sensor_range_error || |ch_bad;
        next_warn_code[wrs_pkg::BIT_RTD0 +: wrs_pkg::RTD_CH] = ch_open;       // R5
        next_warn_code[wrs_pkg::BIT_THERM0 +: 2] = thermistor_open_short; // R6
    end

    // no clear path: the code is rebuilt every cycle from live conditions
    always_ff @(posedge clk_sys) begin
        if (!rstn)
            warn_code <= '0;
        else
            warn_code <= next_warn_code;                              // R2 R3 R18
    end

    // ----------------
    // indicators and output routing
    // ----------------
    logic [wrs_pkg::STAGES-1:0] r1;
    logic [wrs_pkg::STAGES-1:0] r2;
    logic [wrs_pkg::STAGES-1:0] r3;
    logic [wrs_pkg::STAGES-1:0] r4;
    logic [wrs_pkg::STAGES-1:0] r5;

    assign r1 = trip_routing_switchgroups[7:0];
    assign r2 = trip_routing_switchgroups[15:8];
    assign r3 = trip_routing_switchgroups[23:16];
    assign r4 = signal_routing_groups[7:0];
    assign r5 = signal_routing_groups[15:8];

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ready_led              <= 1'b0;
            internal_fault_contact <= 1'b0;
            power_output_one       <= 1'b0;
            power_output_two       <= 1'b0;
            power_output_three     <= 1'b0;
            signal_output_one      <= 1'b0;
            signal_output_two      <= 1'b0;
        end else begin
            ready_led              <= 1'b1;                                 // R1
            internal_fault_contact <= !self_test_fault;                     // R13
            power_output_one       <= |(stage_trip & r1);                   // R14
            power_output_two       <= |(stage_trip & r2);
            power_output_three     <= |(stage_trip & r3) || restart_inhibit; // R15
            signal_output_one      <= |(stage_start_alarm & r4);
            signal_output_two      <= |(stage_start_alarm & r5) ||
                (trip_supervision_route_bit && trip_circuit_fault);         // R7
        end
    end

    // ----------------
    // digital input functions
    // ----------------
    generate
        for (g = 0; g < wrs_pkg::DI_N; g++) begin : g_di
            logic [wrs_pkg::DI_FUNC_W-1:0] fsel;
            assign fsel =
                input_function_switchgroups[g*wrs_pkg::DI_FUNC_W +: wrs_pkg::DI_FUNC_W];
            always_ff @(posedge clk_sys) begin
                if (!rstn) begin
                    di_blocking[g]       <= 1'b0;
                    di_unlatch[g]        <= 1'b0;
                    di_remote_setting[g] <= 1'b0;
                end else begin
                    di_blocking[g]       <= digital_in[g] && fsel[0];   // R17
                    di_unlatch[g]        <= digital_in[g] && fsel[1];
                    di_remote_setting[g] <= digital_in[g] && fsel[2];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (!rstn)
            recorder_trigger <= 1'b0;
        else
            recorder_trigger <= recorder_trigger_select && |digital_in;  // R17
    end

    // ----------------
    // interrupts and read path
    // ----------------
    logic                        all_off_d;
    logic [wrs_pkg::IRQ_W-1:0]   irq_event;

    assign irq_event[wrs_pkg::IRQ_WARN_RISE] = |(next_warn_code & ~warn_code);
    assign irq_event[wrs_pkg::IRQ_ALL_OFF]   = all_inputs_off && !all_off_d;
    assign irq_event[wrs_pkg::IRQ_FAULT]     = self_test_fault;

    // set wins over a same-cycle write-one-to-clear
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            irq_status <= '0;
            all_off_d  <= 1'b0;
        end else begin
            all_off_d  <= all_inputs_off;
            irq_status <= (irq_status & ~((reg_wr && reg_addr == wrs_pkg::ADDR_IRQ_STATUS)
                          ? reg_wdata[wrs_pkg::IRQ_W-1:0] : '0)) | irq_event;
        end
    end

    assign irq = |(irq_status & irq_mask);

    always_ff @(posedge clk_sys) begin
        if (!rstn)
            reg_rdata <= '0;
        else if (reg_rd) begin
            unique case (reg_addr)
                wrs_pkg::ADDR_WARN_CODE:  reg_rdata <= 32'(warn_code);
                wrs_pkg::ADDR_RTD_STATUS: reg_rdata <= {24'h0000_00, all_inputs_off,
                                                        calib_fault_all, rtd_in_service};
                wrs_pkg::ADDR_CTRL:       reg_rdata <= ctrl;
                wrs_pkg::ADDR_TRIP_ROUTE: reg_rdata <= trip_routing_switchgroups;
                wrs_pkg::ADDR_SIG_ROUTE:  reg_rdata <= signal_routing_groups;
                wrs_pkg::ADDR_INPUT_FUNC: reg_rdata <= input_function_switchgroups;
                wrs_pkg::ADDR_IRQ_STATUS: reg_rdata <= 32'(irq_status);
                wrs_pkg::ADDR_IRQ_MASK:   reg_rdata <= 32'(irq_mask);
                default:                  reg_rdata <= '0;
            endcase
        end else
            reg_rdata <= '0;
    end

    // ----------------
    // checks
    // ----------------
    property p_warn_follow;
        @(posedge clk_sys) disable iff (!rstn)
        1 |=> warn_code == $past(next_warn_code);
    endproperty
    a_warn_follow: assert property (p_warn_follow) // R3
        else $error("warning code stale");

    property p_rtd_weight;
        @(posedge clk_sys) disable iff (!rstn)
        sample_accept && sample_open_short && sample_channel < 3'd6
        |=> ##1 warn_code[6 + $past(sample_channel, 2)];
    endproperty
    a_rtd_weight: assert property (p_rtd_weight) // R5
        else $error("open sensor weight missing");

    property p_therm;
        @(posedge clk_sys) disable iff (!rstn)
        thermistor_open_short == 2'b11 |=> warn_code[13:12] == 2'b11;
    endproperty
    a_therm: assert property (p_therm) // R6
        else $error("thermistor weight missing");

    property p_discard;
        @(posedge clk_sys) disable iff (!rstn)
        ref_dev > 16'h0096 |-> !sample_accept;
    endproperty
    a_discard: assert property (p_discard) // R8
        else $error("bad reference sample accepted");

    property p_ref_recover;
        @(posedge clk_sys) disable iff (!rstn)
        sample_valid && ref_dev <= 16'h0096 |=> !ref_fault_all && filter_cnt == '0;
    endproperty
    a_ref_recover: assert property (p_ref_recover) // R10
        else $error("no recovery on good sample");

    property p_calib;
        @(posedge clk_sys) disable iff (!rstn)
        calib_done && !calib_pass |=> rtd_in_service == '0;
    endproperty
    a_calib: assert property (p_calib) // R11
        else $error("inputs in service after failed calibration");

    property p_fault_contact;
        @(posedge clk_sys) disable iff (!rstn)
        self_test_fault |=> !internal_fault_contact ##1 irq_status[2];
    endproperty
    a_fault_contact: assert property (p_fault_contact) // R13
        else $error("fault contact held");

    property p_so2;
        @(posedge clk_sys) disable iff (!rstn)
        stage_start_alarm == '0 && !trip_supervision_route_bit |=> !signal_output_two;
    endproperty
    a_so2: assert property (p_so2) // R7
        else $error("signal output two set without cause");

    property p_ready;
        @(posedge clk_sys) disable iff (!rstn)
        $past(rstn) && warn_code != '0 |-> ready_led;
    endproperty
    a_ready: assert property (p_ready) // R1
        else $error("ready indicator off under warning");

    property p_filter_expire;
        @(posedge clk_sys) disable iff (!rstn)
        filter_cnt == 32'(FILTER_CYCLES - 1) && !(sample_valid && !ref_bad) |=> ref_fault_all;
    endproperty
    a_filter_expire: assert property (p_filter_expire) // R9
        else $error("inputs kept after filter time");

    property p_po_idle;
        @(posedge clk_sys) disable iff (!rstn)
        stage_trip == '0 |=> !power_output_one && !power_output_two;
    endproperty
    a_po_idle: assert property (p_po_idle) // R14
        else $error("power output without trip");

endmodule : warning_and_rtd_supervisor

// >>> hdl/wrs_pkg.sv
package wrs_pkg;
    // ----------------
    // register map
    // ----------------
    localparam logic [7:0] ADDR_WARN_CODE   = 8'h00;
    localparam logic [7:0] ADDR_RTD_STATUS  = 8'h04;
    localparam logic [7:0] ADDR_CTRL        = 8'h08;
    localparam logic [7:0] ADDR_TRIP_ROUTE  = 8'h0C;
    localparam logic [7:0] ADDR_SIG_ROUTE   = 8'h10;
    localparam logic [7:0] ADDR_INPUT_FUNC  = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK    = 8'h1C;

    // ----------------
    // field layout
    // ----------------
    localparam int WARN_W          = 14;
    localparam int RTD_CH          = 6;
    localparam int STAGES          = 8;
    localparam int DI_N            = 5;
    localparam int DI_FUNC_W       = 3;
    localparam int BIT_BATT        = 0;
    localparam int BIT_TCS         = 1;
    localparam int BIT_PSU_TEMP    = 2;
    localparam int BIT_COMM        = 3;
    localparam int BIT_RTD_MOD     = 4;
    localparam int BIT_RANGE       = 5;
    localparam int BIT_RTD0        = 6;
    localparam int BIT_THERM0      = 12;
    localparam int CTRL_TRIP_SUP   = 0;
    localparam int CTRL_REC_TRIG   = 1;
    localparam int IRQ_W           = 3;
    localparam int IRQ_WARN_RISE   = 0;
    localparam int IRQ_ALL_OFF     = 1;
    localparam int IRQ_FAULT       = 2;

    // ----------------
    // range limits, 16-bit full scale 0..10000 = 0..100 percent
    // ----------------
    localparam logic signed [15:0] RANGE_LOW   = -16'sd400;
    localparam logic signed [15:0] RANGE_HIGH  = 16'sd10400;
    localparam logic [15:0]        REF_TOL     = 16'h0096;

    // ----------------
    // reset values
    // ----------------
    localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
    // output three carries only the restart inhibit by default
    localparam logic [31:0] TRIP_ROUTE_RST = 32'h0000_3F3F;
    localparam logic [31:0] SIG_ROUTE_RST  = 32'h0000_3F3F;
    localparam logic [31:0] INPUT_FUNC_RST = 32'h0000_0000;

    // ----------------
    // timing
    // ----------------
    localparam longint CLK_HZ         = 200_000_000;
    localparam longint FILTER_S       = 8;
    localparam longint FILTER_CYCLES  = FILTER_S * CLK_HZ;
endpackage : wrs_pkg

// >>> bench/rtd_sampler.sv
`timescale 1ns/1ps
module rtd_sampler (
    input  wire logic               clk_sys,
    input  wire logic               go,
    input  wire logic [2:0]         ch,
    input  wire logic signed [15:0] val,
    input  wire logic               os,
    input  wire logic [15:0]        dev,
    output logic                    sample_valid,
    output logic [2:0]              sample_channel,
    output logic signed [15:0]      sample_value,
    output logic                    sample_open_short,
    output logic [15:0]             ref_measured,
    output logic [15:0]             ref_setpoint
);
    // ----------------
    // one sample per go pulse
    // ----------------
    // lines invert between samples so a stale value never looks valid
    always_ff @(posedge clk_sys) begin
        sample_valid <= go;
        sample_channel <= go ? ch : ~sample_channel;
        sample_value <= go ? val : ~sample_value;
        sample_open_short <= go ? os : ~sample_open_short;
        ref_setpoint <= 16'h1000;
        ref_measured <= go ? 16'h1000 + dev : ~ref_measured;
    end
endmodule : rtd_sampler

// >>> bench/test_warning_and_rtd_supervisor.sv
`timescale 1ns/1ps
module test_warning_and_rtd_supervisor;
    // short filter keeps the run small
    localparam longint FILT = 20;
    logic clk_sys = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, trip = 8'h00, alrm = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000, rd_val, reg_rdata;
    logic [5:0] wl = 6'h00, rtd_in_service;
    logic [1:0] th = 2'h0;
    logic stf = 1'b0, cdone = 1'b0, cpass = 1'b0, rinh = 1'b0, go = 1'b0, os = 1'b0;
    logic [4:0] din = 5'h00, di_blocking, di_unlatch, di_remote_setting;
    logic [2:0] ch = 3'h0, sample_channel;
    logic signed [15:0] val = 16'h0000, sample_value;
    logic [15:0] dev = 16'h0000, ref_measured, ref_setpoint;
    logic irq, sample_valid, sample_open_short, ready_led, internal_fault_contact, sample_accept;
    logic power_output_one, power_output_two, power_output_three, recorder_trigger;
    logic signal_output_one, signal_output_two;
    int n_errors = 0, cmp_count = 0;

    rtd_sampler i_rtd_sampler (.clk_sys, .go, .ch, .val, .os, .dev, .sample_valid,
        .sample_channel, .sample_value, .sample_open_short, .ref_measured, .ref_setpoint);
    warning_and_rtd_supervisor #(.FILTER_CYCLES(FILT)) i_warning_and_rtd_supervisor (
        .clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
        .battery_low(wl[0]), .trip_circuit_fault(wl[1]), .psu_over_temp(wl[2]),
        .comm_module_fault(wl[3]), .rtd_module_fault(wl[4]), .sensor_range_error(wl[5]),
        .thermistor_open_short(th), .self_test_fault(stf), .sample_valid, .sample_channel,
        .sample_value, .sample_open_short, .ref_measured, .ref_setpoint, .calib_done(cdone),
        .calib_pass(cpass), .stage_trip(trip), .stage_start_alarm(alrm),
        .restart_inhibit(rinh), .digital_in(din), .ready_led, .internal_fault_contact,
        .power_output_one, .power_output_two, .power_output_three, .signal_output_one,
        .signal_output_two, .rtd_in_service, .sample_accept, .di_blocking, .di_unlatch,
        .di_remote_setting, .recorder_trigger);

    always #2.5 clk_sys = ~clk_sys;
    // ----------------
    // shared tasks
    // ----------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : wt
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask : rd
    task automatic send(input logic [2:0] c, input logic [15:0] v, input logic o,
                        input logic [15:0] d);
        @(posedge clk_sys);
        go <= 1'b1;
        ch <= c;
        val <= v;
        os <= o;
        dev <= d;
        @(posedge clk_sys);
        go <= 1'b0;
    endtask : send
    task automatic cal(input logic p);
        @(posedge clk_sys);
        cdone <= 1'b1;
        cpass <= p;
        @(posedge clk_sys);
        cdone <= 1'b0;
        wt(3);
    endtask : cal
    // ----------------
    // scenarios
    // ----------------
    task automatic t_reset();
        chk(ready_led, 1'b1);
        chk(internal_fault_contact, 1'b1);
        rd(wrs_pkg::ADDR_TRIP_ROUTE);
        chk(rd_val, wrs_pkg::TRIP_ROUTE_RST);
        rd(wrs_pkg::ADDR_SIG_ROUTE);
        chk(rd_val, wrs_pkg::SIG_ROUTE_RST);
        rd(8'hFC);
        chk(rd_val, 32'h0000_0000);
        $display("reset test done");
    endtask : t_reset
    task automatic t_warn();
        wr(wrs_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
        for (int i = 0; i < 8; i++) begin
            wl <= (i < 6) ? 6'(1 << i) : 6'h00;
            th <= (i < 6) ? 2'h0 : 2'(1 << (i - 6));
            wt(3);
            rd(wrs_pkg::ADDR_WARN_CODE);
            chk(rd_val, 32'h0000_0001 << ((i < 6) ? i : i + 6));
        end
        chk(irq, 1'b1);
        wl <= 6'h3F;
        th <= 2'h3;
        wt(3);
        // a clear attempt on the code must not stick
        wr(wrs_pkg::ADDR_WARN_CODE, 32'h0000_0000);
        rd(wrs_pkg::ADDR_WARN_CODE);
        chk(rd_val, 32'h0000_303F);
        chk(ready_led, 1'b1);
        wr(wrs_pkg::ADDR_IRQ_STATUS, 32'h0000_0001);
        wt(1);
        chk(irq, 1'b0);
        wl <= 6'h00;
        th <= 2'h0;
        wt(3);
        rd(wrs_pkg::ADDR_WARN_CODE);
        chk(rd_val, 32'h0000_0000);
        $display("warning test done");
    endtask : t_warn
    task automatic t_chan();
        logic [15:0] rv [4] = '{16'h28A0, 16'h28A1, 16'hFE70, 16'hFE6F};
        for (int c = 0; c < 6; c++) begin
            send(3'(c), 16'h1388, 1'b1, 16'h0000);
            wt(4);
            chk(rtd_in_service, 6'h3F ^ 6'(1 << c));
            rd(wrs_pkg::ADDR_WARN_CODE);
            chk(rd_val, 32'h0000_0040 << c);
            send(3'(c), 16'h1388, 1'b0, 16'h0000);
            wt(4);
        end
        // both range edges, inside and one step outside
        for (int k = 0; k < 4; k++) begin
            send(3'h5, rv[k], 1'b0, 16'h0000);
            wt(4);
            chk(rtd_in_service[5], 1'(k % 2 == 0));
            send(3'h5, 16'h1388, 1'b0, 16'h0000);
            wt(4);
        end
        chk(rtd_in_service, 6'h3F);
        $display("channel test done");
    endtask : t_chan
    task automatic t_ref();
        int n = 0;
        for (int k = 0; k < 6; k++) send(3'h2, 16'h1388, 1'b1, 16'h0097);
        #1 chk(sample_accept, 1'b0);
        send(3'h1, 16'h1388, 1'b0, 16'h0096);
        #1 chk(sample_accept, 1'b1);
        for (int k = 0; k < 6; k++) send(3'h2, 16'h1388, 1'b1, 16'h0097);
        chk(rtd_in_service, 6'h3F);
        while (rtd_in_service !== 6'h00 && n < 40) begin
            @(posedge clk_sys);
            n++;
        end
        chk(rtd_in_service, 6'h00);
        if (n == 40) report_and_stop();
        send(3'h0, 16'h1388, 1'b0, 16'h0000);
        wt(4);
        chk(rtd_in_service, 6'h3F);
        $display("reference test done");
    endtask : t_ref
    task automatic t_out();
        cal(1'b0);
        chk(rtd_in_service, 6'h00);
        cal(1'b1);
        chk(rtd_in_service, 6'h3F);
        trip <= 8'h20;
        alrm <= 8'h01;
        wt(3);
        chk({power_output_one, power_output_two, power_output_three, signal_output_one,
             signal_output_two}, 5'h1B);
        trip <= 8'hC0;
        alrm <= 8'h80;
        rinh <= 1'b1;
        wl <= 6'h02;
        wt(3);
        chk({power_output_one, power_output_two, power_output_three, signal_output_one,
             signal_output_two}, 5'h04);
        wr(wrs_pkg::ADDR_CTRL, 32'h0000_0001);
        wt(3);
        chk(signal_output_two, 1'b1);
        wr(wrs_pkg::ADDR_INPUT_FUNC, 32'h0000_00A1);
        din <= 5'h07;
        wr(wrs_pkg::ADDR_CTRL, 32'h0000_0002);
        wt(3);
        chk({di_blocking, di_unlatch, di_remote_setting}, {5'h01, 5'h04, 5'h02});
        chk(recorder_trigger, 1'b1);
        wr(wrs_pkg::ADDR_IRQ_MASK, 32'h0000_0004);
        stf <= 1'b1;
        wt(3);
        chk(internal_fault_contact, 1'b0);
        chk(irq, 1'b1);
        stf <= 1'b0;
        wt(3);
        wr(wrs_pkg::ADDR_IRQ_STATUS, 32'h0000_0004);
        wt(1);
        chk(irq, 1'b0);
        chk(internal_fault_contact, 1'b1);
        $display("output test done");
    endtask : t_out

    initial begin
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        wt(3);
        t_reset();
        t_warn();
        t_chan();
        t_ref();
        t_out();
        report_and_stop();
    end
endmodule : test_warning_and_rtd_supervisor
